// >>> rsc_checker.sv
`timescale 1ns/1ps
module rsc_checker #(
	parameter int unsigned WARMUP_CYC = rsc_pkg::WARMUP_CYC_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic supply_above_release,
	input wire logic wdt_overflow,
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	input wire logic por_active,
	input wire logic core_reset_n,
	input wire logic warmup_active,
	input wire logic [7:0] reset_cause_status,
	input wire logic reset_pin_is_port,
	input wire logic reset_pin_disable
);
	logic [15:0] wcnt_r;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Length of the current warm-up run
	always_ff @(posedge clk) begin
		wcnt_r <= (!reset_n || !warmup_active) ? 16'h0000 : wcnt_r + 16'h0001;
	end
	por_follow_a: assert property (!supply_above_release |=> por_active)
		else $error("por late");
	core_held_a: assert property (por_active |=> !core_reset_n)
		else $error("core ran in por");
	warm_len_a: assert property ($rose(core_reset_n) |-> wcnt_r == WARMUP_CYC)
		else $error("warm-up length");
	fac_reset_a: assert property (core_reset_n && wdt_overflow |-> ##[1:3] !core_reset_n)
		else $error("no factor reset");
	cause_wdt_a: assert property (core_reset_n && wdt_overflow |-> ##[1:3] reset_cause_status[1])
		else $error("cause not set");
	bit7_zero_a: assert property (!reset_cause_status[7])
		else $error("bit 7 set");
	key_clear_a: assert property (core_reset_n && key_wr && key_data == 8'h71
		&& reset_cause_status[6] |=> reset_cause_status == 8'h00)
		else $error("cause not cleared");
	pin_switch_a: assert property (core_reset_n && key_wr && key_data == 8'hb2
		|=> reset_pin_is_port == $past(reset_pin_disable))
		else $error("pin mode");
endmodule
bind rsc_top rsc_checker #(.WARMUP_CYC(WARMUP_CYC)) u_rsc_checker (.clk, .reset_n,
	.supply_above_release, .wdt_overflow, .key_wr, .key_data, .por_active, .core_reset_n,
	.warmup_active, .reset_cause_status, .reset_pin_is_port, .reset_pin_disable);

// >>> rsc_pin_filter.sv
`timescale 1ns/1ps
module rsc_pin_filter (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin_low,
	output logic pin_reset
);
	typedef struct packed {
		logic [15:0] cnt;
		logic hit;
	} rsc_flt_s;
	rsc_flt_s st_r, st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (!pin_low) begin
			st_nxt.cnt = '0;
			st_nxt.hit = 1'b0;
		end else if (st_r.cnt < 16'(rsc_pkg::PIN_LOW_CYC - 1)) begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
		end else begin
			st_nxt.hit = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign pin_reset = st_r.hit;
endmodule

// >>> rsc_pkg.sv
// Operation
// - Voltage detectors disabled only by power-on or pin
// - Power-on reset follows supply comparator level
// - Power-on and pin reset are ORed
// - Warm-up starts when later source releases
// - Core held until warm-up completes
// - Pin low 5us or longer resets device
// - Shared pin is reset input at power-up
// - Voltage detection causes internal factor reset
// - Watchdog overflow causes internal factor reset
// - Clock deadlock setting causes internal factor reset
// - Trimming bits loaded during every warm-up
// - Abnormal trimming bits set trim fault flag
// - Corrupted latched trimming causes internal reset
// - Flash access in standby causes internal reset
// - Cause register cleared by reset only on power-on or pin, except trim fault bit cleared at every warm-up start
// - Clear bit plus key 0x71 clears causes
// - Disable bit plus key 0xb2 switches pin
// - Any reset during warm-up restarts the count
// - Execution starts from vector at top bytes
// - Bit 7 of cause register reads zero
package rsc_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned PIN_LOW_NS = 5000;
	localparam int unsigned PIN_LOW_CYC = (PIN_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned WARMUP_CYC_DEF = 4096;
	localparam logic [7:0] KEY_CAUSE_CLEAR = 8'h71;
	localparam logic [7:0] KEY_PIN_DISABLE = 8'hb2;
	localparam logic [15:0] RESET_VECTOR = 16'hfffe;
	// Cause bit positions
	localparam int unsigned CB_VDET = 0;
	localparam int unsigned CB_WDT = 1;
	localparam int unsigned CB_CLK = 2;
	localparam int unsigned CB_TRIM = 3;
	localparam int unsigned CB_FLASH = 4;
	localparam int unsigned CB_TRIM_FAULT = 5;
	localparam int unsigned CB_CLEAR_REQ = 6;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	typedef enum logic [2:0] {
		RSC_RESET = 3'b001,
		RSC_WARMUP = 3'b010,
		RSC_RUN = 3'b100
	} rsc_state_e;
endpackage

// >>> rsc_supervisor.sv
`timescale 1ns/1ps
module rsc_supervisor (
	input wire logic clk,
	input wire logic hold,
	output logic pin
);
	int cnt = 200;
	// Pin stays low a settle time after hold drops
	always @(posedge clk) begin
		cnt <= hold ? 0 : cnt + (cnt < 200);
	end
	assign pin = !hold && cnt > 126;
endmodule

// >>> rsc_sync.sv
`timescale 1ns/1ps
module rsc_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} rsc_sync_s;
	rsc_sync_s st_r, st_nxt;
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	// Reset to high: pin idles released
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.s2;
endmodule

// >>> rsc_top.sv
`timescale 1ns/1ps
module rsc_top #(
	parameter int unsigned WARMUP_CYC = rsc_pkg::WARMUP_CYC_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic supply_above_release,
	input wire logic reset_pin_in,
	input wire logic vdet_event,
	input wire logic wdt_overflow,
	input wire logic clock_deadlock,
	input wire logic flash_standby_access,
	input wire logic trim_latch_corrupt,
	input wire logic [7:0] trim_store_data,
	input wire logic trim_store_ok,
	input wire logic cause_clear_request_wr,
	input wire logic cause_clear_request_val,
	input wire logic reset_pin_disable_wr,
	input wire logic reset_pin_disable_val,
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	output logic por_active,
	output logic core_reset_n,
	output logic warmup_active,
	output logic vdet_disable,
	output logic [7:0] reset_cause_status,
	output logic [7:0] trim_value,
	output logic reset_pin_is_port,
	output logic port_pin_value,
	output logic reset_pin_disable,
	output logic [15:0] fetch_vector
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		rsc_pkg::rsc_state_e state;
		logic [31:0] wu_cnt;
		logic [7:0] cause;
		logic clr_req;
		logic dis_bit;
		logic pin_port;
		logic [7:0] trim;
		logic vdis;
		logic por_q;
		logic ext_hold;
	} rsc_top_s;
	rsc_top_s st_r, st_nxt;

	logic pin_s;
	logic pin_reset;
	logic factor_any;
	logic ext_reset;

	function automatic logic key_match(input logic [7:0] d, input logic [7:0] k);
		key_match = (d == k);
	endfunction

	// ----------------------------------------
	// Pin path
	// ----------------------------------------
	rsc_sync u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(reset_pin_in),
		.q(pin_s)
	);
	rsc_pin_filter u_filter (
		.clk(clk),
		.reset_n(reset_n),
		.pin_low(!pin_s && !st_r.pin_port),
		.pin_reset(pin_reset)
	);

	// Pin reset holds until pin returns high
	assign ext_reset = pin_reset || (st_r.ext_hold && !pin_s);
	assign factor_any = vdet_event || wdt_overflow || clock_deadlock
		|| flash_standby_access || trim_latch_corrupt;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.por_q = !supply_above_release;
		st_nxt.ext_hold = ext_reset;
		if (st_r.por_q || ext_reset) begin
			st_nxt.state = rsc_pkg::RSC_RESET;
			st_nxt.wu_cnt = '0;
			st_nxt.cause = rsc_pkg::CAUSE_RESET;
			st_nxt.clr_req = 1'b0;
			st_nxt.dis_bit = 1'b0;
			st_nxt.vdis = 1'b1;
			if (st_r.por_q) begin
				st_nxt.pin_port = 1'b0;
			end
		end else if (factor_any) begin
			st_nxt.state = rsc_pkg::RSC_RESET;
			st_nxt.wu_cnt = '0;
			if (vdet_event) st_nxt.cause[rsc_pkg::CB_VDET] = 1'b1;
			if (wdt_overflow) st_nxt.cause[rsc_pkg::CB_WDT] = 1'b1;
			if (clock_deadlock) st_nxt.cause[rsc_pkg::CB_CLK] = 1'b1;
			if (trim_latch_corrupt) st_nxt.cause[rsc_pkg::CB_TRIM] = 1'b1;
			if (flash_standby_access) st_nxt.cause[rsc_pkg::CB_FLASH] = 1'b1;
		end else begin
			case (st_r.state)
				rsc_pkg::RSC_RESET: begin
					st_nxt.state = rsc_pkg::RSC_WARMUP;
					st_nxt.wu_cnt = '0;
					st_nxt.cause[rsc_pkg::CB_TRIM_FAULT] = 1'b0;
				end
				rsc_pkg::RSC_WARMUP: begin
					if (st_r.wu_cnt == 32'h00000000) begin
						st_nxt.trim = trim_store_data;
						if (!trim_store_ok) begin
							st_nxt.cause[rsc_pkg::CB_TRIM_FAULT] = 1'b1;
						end
					end
					if (st_r.wu_cnt >= WARMUP_CYC - 1) begin
						st_nxt.state = rsc_pkg::RSC_RUN;
					end else begin
						st_nxt.wu_cnt = st_r.wu_cnt + 32'h00000001;
					end
				end
				rsc_pkg::RSC_RUN: begin
					st_nxt.vdis = 1'b0;
					if (cause_clear_request_wr) st_nxt.clr_req = cause_clear_request_val;
					if (reset_pin_disable_wr) st_nxt.dis_bit = reset_pin_disable_val;
					if (key_wr && key_match(key_data, rsc_pkg::KEY_CAUSE_CLEAR)
						&& st_r.clr_req) begin
						st_nxt.cause = '0;
						st_nxt.clr_req = 1'b0;
					end
					if (key_wr && key_match(key_data, rsc_pkg::KEY_PIN_DISABLE)) begin
						st_nxt.pin_port = st_r.dis_bit;
					end
				end
				default: begin
					st_nxt.state = rsc_pkg::RSC_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r.state <= rsc_pkg::RSC_RESET;
			st_r.wu_cnt <= '0;
			st_r.cause <= rsc_pkg::CAUSE_RESET;
			st_r.clr_req <= 1'b0;
			st_r.dis_bit <= 1'b0;
			st_r.pin_port <= 1'b0;
			st_r.trim <= rsc_pkg::TRIM_RESET;
			st_r.vdis <= 1'b1;
			st_r.por_q <= 1'b1;
			st_r.ext_hold <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign por_active = st_r.por_q;
	assign core_reset_n = (st_r.state == rsc_pkg::RSC_RUN);
	assign warmup_active = (st_r.state == rsc_pkg::RSC_WARMUP);
	assign vdet_disable = st_r.vdis;
	assign reset_cause_status = {1'b0, st_r.clr_req, st_r.cause[5:0]};
	assign trim_value = st_r.trim;
	assign reset_pin_is_port = st_r.pin_port;
	assign port_pin_value = pin_s;
	assign reset_pin_disable = st_r.dis_bit;
	assign fetch_vector = rsc_pkg::RESET_VECTOR;
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic sup = 1'h0;
	logic hold = 1'h0;
	logic tok = 1'h1;
	logic cwr = 1'h0;
	logic dwr = 1'h0;
	logic bv = 1'h0;
	logic kwr = 1'h0;
	logic [4:0] fac = 5'h00;
	logic [7:0] tdat = 8'h5a;
	logic [7:0] kdat = 8'h00;
	logic pin, por, crn, wup, vdd, isp, ppv, rpd;
	logic [7:0] cause, trim;
	logic [15:0] vec;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	always #20 clk = !clk;
	rsc_supervisor u_rsc_supervisor (.clk(clk), .hold(hold), .pin(pin));
	rsc_top #(.WARMUP_CYC(16)) u_rsc_top (.clk(clk), .reset_n(reset_n),
		.supply_above_release(sup), .reset_pin_in(pin), .vdet_event(fac[0]),
		.wdt_overflow(fac[1]), .clock_deadlock(fac[2]), .trim_latch_corrupt(fac[3]),
		.flash_standby_access(fac[4]), .trim_store_data(tdat), .trim_store_ok(tok),
		.cause_clear_request_wr(cwr), .cause_clear_request_val(bv),
		.reset_pin_disable_wr(dwr), .reset_pin_disable_val(bv), .key_wr(kwr),
		.key_data(kdat), .por_active(por), .core_reset_n(crn), .warmup_active(wup),
		.vdet_disable(vdd), .reset_cause_status(cause), .trim_value(trim),
		.reset_pin_is_port(isp), .port_pin_value(ppv), .reset_pin_disable(rpd),
		.fetch_vector(vec));
	task automatic test_done();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// Wait for reset, then for the core to run
	task automatic wrun();
		int k;
		int w;
		k = 0;
		w = 0;
		while (crn !== 1'h0 && k < 9) begin
			tick(1);
			k++;
		end
		while (crn !== 1'h1 && k < 400) begin
			w = wup === 1'h1 ? w + 1 : 0;
			tick(1);
			k++;
		end
		chk("warmup", 16'h0010, 16'(w));
	endtask
	task automatic pulse(logic [4:0] v);
		fac = v;
		tick(1);
		fac = 5'h00;
		wrun();
	endtask
	task automatic wbit(logic d, logic v);
		cwr = !d;
		dwr = d;
		bv = v;
		tick(1);
		cwr = 1'h0;
		dwr = 1'h0;
	endtask
	task automatic key(logic [7:0] v);
		kwr = 1'h1;
		kdat = v;
		tick(1);
		kwr = 1'h0;
		tick(1);
	endtask
	initial begin
		tick(12);
		reset_n = 1'h1;
		tick(3);
		chk("por", 16'h0001, por);
		chk("core", 16'h0000, crn);
		sup = 1'h1;
		wrun();
		chk("cause", 16'h0000, cause);
		chk("is_port", 16'h0000, isp);
		chk("vector", 16'hfffe, vec);
		chk("trim", 16'h005a, trim);
		tick(1);
		chk("vdet_off", 16'h0000, vdd);
		for (int i = 0; i < 5; i++) begin
			pulse(5'h01 << i);
			chk("cause", 16'((2 << i) - 1), cause);
			chk("vdet_off", 16'h0000, vdd);
		end
		tok = 1'h0;
		pulse(5'h04);
		chk("trim_fault", 16'h0001, cause[5]);
		tok = 1'h1;
		tdat = 8'ha5;
		pulse(5'h04);
		chk("trim_fault", 16'h0000, cause[5]);
		chk("trim", 16'h00a5, trim);
		hold = 1'h1;
		tick(5);
		hold = 1'h0;
		tick(125);
		chk("core", 16'h0000, crn);
		chk("vdet_off", 16'h0001, vdd);
		chk("cause", 16'h0000, cause);
		wrun();
		pulse(5'h10);
		wbit(1'h0, 1'h1);
		key(8'h72);
		chk("cause", 16'h0050, cause);
		key(8'h71);
		chk("cause", 16'h0000, cause);
		wbit(1'h1, 1'h1);
		chk("dis_bit", 16'h0001, rpd);
		key(8'h00);
		chk("is_port", 16'h0000, isp);
		key(8'hb2);
		chk("is_port", 16'h0001, isp);
		hold = 1'h1;
		tick(60);
		chk("port_val", 16'h0000, ppv);
		hold = 1'h0;
		tick(140);
		chk("core", 16'h0001, crn);
		wbit(1'h1, 1'h0);
		key(8'hb2);
		chk("is_port", 16'h0000, isp);
		chk("dis_bit", 16'h0000, rpd);
		wbit(1'h1, 1'h1);
		key(8'hb2);
		chk("is_port", 16'h0001, isp);
		sup = 1'h0;
		tick(3);
		sup = 1'h1;
		tick(6);
		sup = 1'h0;
		tick(2);
		sup = 1'h1;
		wrun();
		chk("is_port", 16'h0000, isp);
		hold = 1'h1;
		sup = 1'h0;
		tick(200);
		sup = 1'h1;
		tick(40);
		chk("core", 16'h0000, crn);
		hold = 1'h0;
		wrun();
		test_done();
	end
endmodule
